/* File: core/hsc_pwm_gen.sv */
`timescale 1ns/10ps
`default_nettype none
module hsc_pwm_gen (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic [7:0] duty_in,
   input  wire logic       fast_in,
   output logic            pwm_out
);
   logic [15:0] tick_cnt_reg;
   logic [7:0]  phase_reg;
   logic        pwm_reg;
   logic [15:0] tick_max;
   logic        tick;

   assign tick_max = fast_in ? 16'(hsc_pkg::TICK_HI_CYC - 1) : 16'(hsc_pkg::TICK_LO_CYC - 1);
   assign tick     = (tick_cnt_reg >= tick_max);
   assign pwm_out  = pwm_reg;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tick_cnt_reg <= 16'h0000;
         phase_reg    <= 8'h00;
         pwm_reg      <= 1'b0;
      end else begin
         tick_cnt_reg <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
         if (tick) begin
            phase_reg <= phase_reg + 8'h01;
         end
         pwm_reg <= (phase_reg < duty_in);
      end
   end
endmodule // hsc_pwm_gen
`default_nettype wire

/* File: core/hsc_switch_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
// How it works
// - outputs driven direct, timer, or PWM
// - stop/sleep freeze configuration, reject writes
// - restart/fail-safe disable every output
// - overvoltage switches outputs off unless disabled
// - undervoltage switches outputs off unless disabled
// - recovery restores state, else clears config
// - supply faults flag only their bits
// - overcurrent past filter switches output off
// - overcurrent latches flag, resets config 000
// - open load latches flag, output stays
// - open load flag cleared only by software
// - protections active in stop and sleep
// - configured outputs keep running in low power
// - two PWM generators, 8-bit duty each
// - per-generator 200 or 400 Hz select
// - any output takes any of five sources
// - PWM starts as soon as assigned
module hsc_switch_ctrl (
   input  wire logic        SYS_CLK_IN,
   input  wire logic        RSTN_IN,
   input  wire logic [2:0]  SYS_MODE_IN,
   input  wire logic        CFG_WR_IN,
   input  wire logic [5:0]  OUTPUT_CONTROL_A_IN,
   input  wire logic [5:0]  OUTPUT_CONTROL_B_IN,
   input  wire logic [7:0]  DUTY_SETTING_ONE_IN,
   input  wire logic [7:0]  DUTY_SETTING_TWO_IN,
   input  wire logic [1:0]  PULSE_FREQUENCY_SELECT_IN,
   input  wire logic [2:0]  SUPPLY_CFG_IN,
   input  wire logic [3:0]  OC_CLEAR_IN,
   input  wire logic [3:0]  OL_CLEAR_IN,
   input  wire logic [1:0]  TIMER_IN,
   input  wire logic        SWITCH_SUPPLY_OV_IN,
   input  wire logic        SWITCH_SUPPLY_UV_IN,
   input  wire logic [3:0]  OVERCURRENT_IN,
   input  wire logic [3:0]  UNDERCURRENT_IN,
   output logic      [3:0]  SWITCH_OUTPUT_OUT,
   output logic      [11:0] CONFIG_OUT,
   output logic      [9:0]  STATUS_OUT,
   output logic             CFG_REJECT_OUT
);
   localparam int N = hsc_pkg::NUM_CH;

   function automatic logic [2:0] ch_cfg(input logic [11:0] v, input int i);
      ch_cfg = v[i*3 +: 3];
   endfunction

   logic                  rst_meta_reg;
   logic                  rst_n;
   logic [2:0]            mode_meta_reg;
   logic [2:0]            mode_reg;
   logic [1:0]            ovuv_meta_reg;
   logic [1:0]            ovuv_reg;
   logic [N-1:0]          oc_meta_reg;
   logic [N-1:0]          oc_sync_reg;
   logic [N-1:0]          uc_meta_reg;
   logic [N-1:0]          uc_sync_reg;
   logic [1:0]            tmr_meta_reg;
   logic [1:0]            tmr_reg;

   logic [11:0]           cfg_reg;
   logic [11:0]           cfg_next;
   logic [7:0]            duty1_reg;
   logic [7:0]            duty2_reg;
   logic [1:0]            fsel_reg;
   hsc_pkg::hsc_supcfg_s  sup_cfg_reg;
   hsc_pkg::hsc_status_s  stat_reg;
   hsc_pkg::hsc_status_s  stat_next;
   hsc_pkg::hsc_sup_e     sup_reg;
   hsc_pkg::hsc_sup_e     sup_next;
   logic [N-1:0][10:0]    oc_cnt_reg;
   logic [N-1:0][12:0]    ol_cnt_reg;
   logic [N-1:0]          oc_trip;
   logic [N-1:0]          ol_trip;
   logic [N-1:0]          drive;
   logic [N-1:0]          out_reg;
   logic [1:0]            pwm;
   logic                  cfg_reject_reg;

   wire       mode_normal  = (mode_reg == hsc_pkg::HSC_MODE_NORMAL);
   wire       mode_off     = (mode_reg == hsc_pkg::HSC_MODE_RESTART) ||
                             (mode_reg == hsc_pkg::HSC_MODE_FAILSAFE);
   wire       cfg_accept   = CFG_WR_IN && mode_normal;
   wire       ov_kill      = ovuv_reg[1] && !sup_cfg_reg.overvoltage_shutdown_cfg;
   wire       uv_kill      = ovuv_reg[0] && !sup_cfg_reg.undervoltage_shutdown_cfg;
   wire       sup_fault    = ov_kill || uv_kill;
   wire       sup_block    = (sup_reg != hsc_pkg::HSC_SUP_OK);
   wire       sup_release  = (sup_reg == hsc_pkg::HSC_SUP_FAULT) && !sup_fault;

   hsc_pwm_gen u_pwm1 (
      .clk_in   (SYS_CLK_IN),
      .rst_n_in (rst_n),
      .duty_in  (duty1_reg),
      .fast_in  (fsel_reg[0]),
      .pwm_out  (pwm[0])
   );

   hsc_pwm_gen u_pwm2 (
      .clk_in   (SYS_CLK_IN),
      .rst_n_in (rst_n),
      .duty_in  (duty2_reg),
      .fast_in  (fsel_reg[1]),
      .pwm_out  (pwm[1])
   );

   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   // two-stage sync of mode, supply, current and timer inputs
   always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         mode_meta_reg <= 3'h0;
         mode_reg      <= 3'h0;
         ovuv_meta_reg <= 2'h0;
         ovuv_reg      <= 2'h0;
         oc_meta_reg   <= 4'h0;
         oc_sync_reg   <= 4'h0;
         uc_meta_reg   <= 4'h0;
         uc_sync_reg   <= 4'h0;
         tmr_meta_reg  <= 2'h0;
         tmr_reg       <= 2'h0;
      end else begin
         mode_meta_reg <= SYS_MODE_IN;
         mode_reg      <= mode_meta_reg;
         ovuv_meta_reg <= {SWITCH_SUPPLY_OV_IN, SWITCH_SUPPLY_UV_IN};
         ovuv_reg      <= ovuv_meta_reg;
         oc_meta_reg   <= OVERCURRENT_IN;
         oc_sync_reg   <= oc_meta_reg;
         uc_meta_reg   <= UNDERCURRENT_IN;
         uc_sync_reg   <= uc_meta_reg;
         tmr_meta_reg  <= TIMER_IN;
         tmr_reg       <= tmr_meta_reg;
      end
   end

   // filter counters: run while condition holds on an active output
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_filt
         assign oc_trip[g] = (oc_cnt_reg[g] >= 11'(hsc_pkg::OC_FILTER_CYC));
         assign ol_trip[g] = (ol_cnt_reg[g] >= 13'(hsc_pkg::OL_FILTER_CYC));
         always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
            if (!rst_n) begin
               oc_cnt_reg[g] <= 11'h000;
               ol_cnt_reg[g] <= 13'h0000;
            end else begin
               oc_cnt_reg[g] <= (out_reg[g] && oc_sync_reg[g] && !oc_trip[g]) ?
                                oc_cnt_reg[g] + 11'h001 : 11'h000;
               ol_cnt_reg[g] <= (out_reg[g] && uc_sync_reg[g] && !ol_trip[g]) ?
                                ol_cnt_reg[g] + 13'h0001 : 13'h0000;
            end
         end
      end
   endgenerate

   // supply fault tracking
   always_comb begin
      sup_next = sup_reg;
      case (sup_reg)
         hsc_pkg::HSC_SUP_OK: begin
            if (sup_fault) begin
               sup_next = hsc_pkg::HSC_SUP_FAULT;
            end
         end
         hsc_pkg::HSC_SUP_FAULT: begin
            if (!sup_fault) begin
               sup_next = hsc_pkg::HSC_SUP_OK;
            end
         end
         default: begin
            sup_next = hsc_pkg::HSC_SUP_OK;
         end
      endcase
   end

   // configuration next value
   always_comb begin
      cfg_next = cfg_reg;
      if (cfg_accept) begin
         cfg_next = {OUTPUT_CONTROL_B_IN, OUTPUT_CONTROL_A_IN};
      end
      if (sup_release && !sup_cfg_reg.supply_fault_recovery) begin
         cfg_next = 12'h000;
      end
      for (int i = 0; i < N; i++) begin
         if (oc_trip[i]) begin
            cfg_next[i*3 +: 3] = hsc_pkg::CFG_OFF;
         end
      end
   end

   // latched oc/ol flags: hardware set wins over software clear; supply flags follow their inputs
   always_comb begin
      stat_next              = stat_reg;
      stat_next.overcurrent  = (stat_reg.overcurrent & ~OC_CLEAR_IN) | oc_trip;
      stat_next.open_load    = (stat_reg.open_load & ~OL_CLEAR_IN) | ol_trip;
      stat_next.overvoltage  = ovuv_reg[1];
      stat_next.undervoltage = ovuv_reg[0];
   end

   // source selection per output
   always_comb begin
      for (int i = 0; i < N; i++) begin
         case (ch_cfg(cfg_reg, i))
            hsc_pkg::CFG_ON:     drive[i] = 1'b1;
            hsc_pkg::CFG_TIMER1: drive[i] = tmr_reg[0];
            hsc_pkg::CFG_TIMER2: drive[i] = tmr_reg[1];
            hsc_pkg::CFG_PWM1:   drive[i] = pwm[0];
            hsc_pkg::CFG_PWM2:   drive[i] = pwm[1];
            default:             drive[i] = 1'b0;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         cfg_reg        <= 12'h000;
         duty1_reg      <= hsc_pkg::DUTY_RESET;
         duty2_reg      <= hsc_pkg::DUTY_RESET;
         fsel_reg       <= 2'h0;
         sup_cfg_reg    <= '0;
         stat_reg       <= '0;
         sup_reg        <= hsc_pkg::HSC_SUP_OK;
         out_reg        <= 4'h0;
         cfg_reject_reg <= 1'b0;
      end else begin
         cfg_reg        <= cfg_next;
         stat_reg       <= stat_next;
         sup_reg        <= sup_next;
         cfg_reject_reg <= CFG_WR_IN && !mode_normal;
         if (cfg_accept) begin
            duty1_reg   <= DUTY_SETTING_ONE_IN;
            duty2_reg   <= DUTY_SETTING_TWO_IN;
            fsel_reg    <= PULSE_FREQUENCY_SELECT_IN;
            sup_cfg_reg <= SUPPLY_CFG_IN;
         end
         // low-power modes keep running from frozen config
         out_reg <= (mode_off || sup_fault || sup_block) ? 4'h0 : (drive & ~oc_trip);
      end
   end

   assign SWITCH_OUTPUT_OUT = out_reg;
   assign CONFIG_OUT        = cfg_reg;
   assign STATUS_OUT        = stat_reg;
   assign CFG_REJECT_OUT    = cfg_reject_reg;
endmodule // hsc_switch_ctrl
`default_nettype wire

/* File: pkg/hsc_pkg.sv */
`default_nettype none
package hsc_pkg;
   localparam int         NUM_CH        = 4;
   localparam int         CLK_HZ        = 100_000_000;
   localparam int         OC_FILTER_US  = 16;
   localparam int         OL_FILTER_US  = 64;
   localparam int         OC_FILTER_CYC = (OC_FILTER_US * (CLK_HZ / 1_000_000));
   localparam int         OL_FILTER_CYC = (OL_FILTER_US * (CLK_HZ / 1_000_000));
   localparam int         PWM_FREQ_LO   = 200;
   localparam int         PWM_FREQ_HI   = 400;
   localparam int         PWM_STEPS     = 256;
   localparam int         TICK_LO_CYC   = CLK_HZ / (PWM_FREQ_LO * PWM_STEPS);
   localparam int         TICK_HI_CYC   = CLK_HZ / (PWM_FREQ_HI * PWM_STEPS);
   localparam logic [2:0] CFG_OFF       = 3'h0;
   localparam logic [2:0] CFG_ON        = 3'h1;
   localparam logic [2:0] CFG_TIMER1    = 3'h2;
   localparam logic [2:0] CFG_TIMER2    = 3'h3;
   localparam logic [2:0] CFG_PWM1      = 3'h4;
   localparam logic [2:0] CFG_PWM2      = 3'h5;
   localparam logic [7:0] DUTY_RESET    = 8'h00;

   typedef enum logic [2:0] {
      HSC_MODE_NORMAL   = 3'h0,
      HSC_MODE_STOP     = 3'h1,
      HSC_MODE_SLEEP    = 3'h3,
      HSC_MODE_RESTART  = 3'h2,
      HSC_MODE_FAILSAFE = 3'h6
   } hsc_mode_e;

   typedef enum logic [1:0] {
      HSC_SUP_OK      = 2'h0,
      HSC_SUP_FAULT   = 2'h1,
      HSC_SUP_LOCKOUT = 2'h3
   } hsc_sup_e;

   typedef struct packed {
      logic [NUM_CH-1:0] overcurrent;
      logic [NUM_CH-1:0] open_load;
      logic              overvoltage;
      logic              undervoltage;
   } hsc_status_s;

   typedef struct packed {
      logic overvoltage_shutdown_cfg;
      logic undervoltage_shutdown_cfg;
      logic supply_fault_recovery;
   } hsc_supcfg_s;
endpackage
`default_nettype wire

/* File: test/hsc_load_model.sv */
`timescale 1ns/10ps
`default_nettype none
module hsc_load_model (
   input  wire logic [3:0] switch_in,
   input  wire logic [3:0] short_in,
   input  wire logic [3:0] open_in,
   output logic      [3:0] overcurrent_out,
   output logic      [3:0] undercurrent_out
);
   // current flows only while the switch conducts
   assign overcurrent_out  = switch_in & short_in;
   assign undercurrent_out = open_in | ~switch_in;
endmodule // hsc_load_model
`default_nettype wire

/* File: test/hsc_switch_ctrl_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module hsc_chk (
   input wire logic        SYS_CLK_IN,
   input wire logic        RSTN_IN,
   input wire logic [2:0]  SYS_MODE_IN,
   input wire logic        CFG_WR_IN,
   input wire logic [5:0]  OUTPUT_CONTROL_A_IN,
   input wire logic [2:0]  SUPPLY_CFG_IN,
   input wire logic [3:0]  OL_CLEAR_IN,
   input wire logic        SWITCH_SUPPLY_OV_IN,
   input wire logic        SWITCH_SUPPLY_UV_IN,
   input wire logic [3:0]  OVERCURRENT_IN,
   input wire logic [3:0]  UNDERCURRENT_IN,
   input wire logic [3:0]  SWITCH_OUTPUT_OUT,
   input wire logic [11:0] CONFIG_OUT,
   input wire logic [9:0]  STATUS_OUT,
   input wire logic        CFG_REJECT_OUT
);
   logic [12:0] nrm, lp, rf, ovd, okc, occ, olc;
   // saturating run length of a condition
   function automatic logic [12:0] run(input logic c, input logic [12:0] n);
      return c ? n + 13'(n != 13'h1fff) : 13'h0;
   endfunction
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         {nrm, lp, rf, ovd, okc, occ, olc} <= '0;
      end else begin
         nrm <= run(SYS_MODE_IN == 3'h0, nrm);
         lp  <= run(SYS_MODE_IN inside {3'h1, 3'h3}, lp);
         rf  <= run(SYS_MODE_IN inside {3'h2, 3'h6}, rf);
         ovd <= run(SWITCH_SUPPLY_OV_IN && !SUPPLY_CFG_IN[2], ovd);
         okc <= run(!SWITCH_SUPPLY_OV_IN && !SWITCH_SUPPLY_UV_IN, okc);
         occ <= run(OVERCURRENT_IN[0], occ);
         olc <= run(UNDERCURRENT_IN[0], olc);
      end
   end
   default clocking dcb @(posedge SYS_CLK_IN);
   endclocking
   default disable iff (!RSTN_IN);
   sequence s_wr_on;
      CFG_WR_IN && nrm > 3 && okc > 5 && OUTPUT_CONTROL_A_IN[2:0] == 3'h1 && !OVERCURRENT_IN[0];
   endsequence
   sequence s_turns_on;
      ##1 CONFIG_OUT[2:0] == 3'h1 ##1 SWITCH_OUTPUT_OUT[0];
   endsequence
   a_write_on: assert property (s_wr_on |-> s_turns_on)
      else $error("write did not switch on");
   a_lp_reject: assert property (CFG_WR_IN && lp > 3 |=> CFG_REJECT_OUT)
      else $error("write not refused");
   a_rf_off: assert property (rf > 4 |-> SWITCH_OUTPUT_OUT == 4'h0)
      else $error("output on in restart");
   a_ov_off: assert property (ovd > 4 |-> SWITCH_OUTPUT_OUT == 4'h0)
      else $error("output on in overvoltage");
   a_sup_only: assert property ($rose(STATUS_OUT[1]) |-> $stable(STATUS_OUT[9:2]))
      else $error("supply fault touched other flags");
   a_oc_trip: assert property ($rose(STATUS_OUT[6]) |-> occ inside {[13'd1600:13'd1610]}
      && CONFIG_OUT[2:0] == 3'h0 && !SWITCH_OUTPUT_OUT[0])
      else $error("overcurrent trip wrong");
   a_ol_keep: assert property ($rose(STATUS_OUT[2]) |-> olc >= 13'd6400
      && SWITCH_OUTPUT_OUT[0])
      else $error("open load flag wrong");
   a_ol_hold: assert property (STATUS_OUT[2] && !OL_CLEAR_IN[0] |=> STATUS_OUT[2])
      else $error("open load flag lost");
endmodule // hsc_chk
bind hsc_switch_ctrl hsc_chk i_chk (.*);
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, ov = 1'b0, uv = 1'b0, rej;
   logic [2:0]  mode = 3'h0, sup = 3'h0;
   logic [5:0]  ca = 6'h0, cb = 6'h0;
   logic [1:0]  tm = 2'h0, fq = 2'h0;
   logic [3:0]  occ = 4'h0, olc = 4'h0, shrt = 4'h0, opn = 4'h0, oc, uc, so;
   logic [11:0] cfg;
   logic [9:0]  st;
   logic [7:0]  d1 = 8'hff, d2 = 8'h00;
   int          n_errors = 0, check_count = 0, rejs = 0, cyc = 0;
   hsc_switch_ctrl i_dut (.SYS_CLK_IN(clk), .RSTN_IN(rst_n), .SYS_MODE_IN(mode),
      .CFG_WR_IN(wr), .OUTPUT_CONTROL_A_IN(ca), .OUTPUT_CONTROL_B_IN(cb),
      .DUTY_SETTING_ONE_IN(d1), .DUTY_SETTING_TWO_IN(d2),
      .PULSE_FREQUENCY_SELECT_IN(fq), .SUPPLY_CFG_IN(sup), .OC_CLEAR_IN(occ),
      .OL_CLEAR_IN(olc), .TIMER_IN(tm), .SWITCH_SUPPLY_OV_IN(ov), .SWITCH_SUPPLY_UV_IN(uv),
      .OVERCURRENT_IN(oc), .UNDERCURRENT_IN(uc), .SWITCH_OUTPUT_OUT(so),
      .CONFIG_OUT(cfg), .STATUS_OUT(st), .CFG_REJECT_OUT(rej));
   hsc_load_model i_load (.switch_in(so), .short_in(shrt), .open_in(opn),
      .overcurrent_out(oc), .undercurrent_out(uc));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic cy(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr_cfg(input logic [5:0] a, input logic [5:0] b);
      @(posedge clk);
      ca <= a;
      cb <= b;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      cy(4);
   endtask
   task automatic final_report;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // pwm one runs at full duty, pwm two at zero
   function automatic logic [3:0] out_of(input logic [11:0] c, input logic [1:0] t);
      for (int i = 0; i < 4; i++) begin
         case (c[3*i +: 3])
            hsc_pkg::CFG_ON, hsc_pkg::CFG_PWM1: out_of[i] = 1'b1;
            hsc_pkg::CFG_TIMER1: out_of[i] = t[0];
            hsc_pkg::CFG_TIMER2: out_of[i] = t[1];
            default: out_of[i] = 1'b0;
         endcase
      end
   endfunction
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rej === 1'b1) begin
         rejs <= rejs + 1;
      end
      if (cyc == 40000) begin
         n_errors = n_errors + 1;
         final_report();
      end
   end
   initial begin
      logic [11:0] c;
      int          r;
      void'($urandom(32'h3ace));
      cy(5);
      rst_n <= 1'b1;
      cy(3);
      for (int k = 0; k < 16; k++) begin
         c = (k < 8) ? {4{3'(k)}} : 12'($urandom);
         tm <= 2'($urandom);
         fq <= 2'($urandom);
         wr_cfg(c[5:0], c[11:6]);
         chk(cfg, c);
         chk(12'(so), 12'(out_of(c, tm)));
      end
      // swapped duties: generators must be independent
      d1 <= 8'h00;
      d2 <= 8'hff;
      wr_cfg(6'h2c, 6'h0);
      chk(12'(so), 12'h2);
      d1 <= 8'hff;
      d2 <= 8'h00;
      for (int i = 0; i < 2; i++) begin
         wr_cfg(6'h21, 6'h0);
         mode <= i ? 3'h3 : 3'h1;
         cy(4);
         r = rejs;
         wr_cfg(6'h0, 6'h0);
         chk(12'(rejs - r), 12'h1);
         chk(cfg, 12'h021);
         chk(12'(so), 12'h3);
         opn <= 4'h1;
         cy(6300);
         chk(12'(st[2]), 12'h0);
         cy(200);
         chk(12'({st[2], so[0]}), 12'h3);
         opn <= 4'h0;
         cy(9);
         chk(12'(st[2]), 12'h1);
         olc <= 4'h1;
         cy(1);
         olc <= 4'h0;
         cy(3);
         chk(12'(st[2]), 12'h0);
         mode <= i ? 3'h6 : 3'h2;
         cy(5);
         chk(12'(so), 12'h0);
         mode <= 3'h0;
         cy(4);
      end
      for (int k = 0; k < 6; k++) begin
         sup <= (k % 3 == 2) ? ((k < 3) ? 3'h5 : 3'h3) : 3'(k % 3);
         wr_cfg(6'h21, 6'h0);
         ov <= (k < 3);
         uv <= (k > 2);
         cy(6);
         chk(12'(st), (k < 3) ? 12'h2 : 12'h1);
         chk(12'(so), (k % 3 == 2) ? 12'h3 : 12'h0);
         ov <= 1'b0;
         uv <= 1'b0;
         cy(6);
         chk(cfg, (k % 3 == 0) ? 12'h0 : 12'h021);
         chk(12'(so), (k % 3 == 0) ? 12'h0 : 12'h3);
      end
      sup <= 3'h0;
      wr_cfg(6'h21, 6'h0);
      shrt <= 4'h1;
      cy(1590);
      chk(12'(so), 12'h3);
      cy(20);
      chk(12'(so), 12'h2);
      chk(cfg, 12'h020);
      shrt <= 4'h0;
      cy(9);
      chk(12'(st[9:6]), 12'h1);
      occ <= 4'h1;
      cy(1);
      occ <= 4'h0;
      wr_cfg(6'h21, 6'h0);
      chk(12'({st[9:6], so}), 12'h03);
      final_report();
   end
endmodule // tb_top
`default_nettype wire
